// >>> logic/sml_fifo_level.v
/*
  FIFO occupancy, receive threshold and interrupt logic of the serial master,
  with an AHB-Lite register slave.
  Assumes push and pop strobes come from the FIFO logic on hclk, and that the
  bus master holds hwdata through the data phase.
*/
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "sml_regs.vh"

module sml_fifo_level #(
   parameter [`SML_LVL_MSB:0] TX_DEPTH = `SML_FIFO_DEPTH,
   parameter [`SML_LVL_MSB:0] RX_DEPTH = `SML_FIFO_DEPTH
)
(
   input wire hclk, // Bus clock, 200 MHz.
   input wire hresetn, // Asynchronous reset, active low.
   input wire hce, // Clock enable; all state frozen while low.
   input wire hsel, // Slave select.
   input wire [31:0] haddr, // Byte address.
   input wire [1:0] htrans, // Transfer type.
   input wire hwrite, // Write when high.
   input wire [2:0] hsize, // Transfer size.
   input wire [31:0] hwdata, // Write data.
   input wire hready, // Bus ready in.
   output wire hreadyout, // Slave ready.
   output wire hresp, // Response, always OKAY.
   output wire [31:0] hrdata, // Read data.
   input wire tx_push, // Transmit FIFO write strobe.
   input wire tx_pop, // Transmit FIFO read strobe.
   input wire rx_push, // Receive FIFO write strobe.
   input wire rx_pop, // Receive FIFO read strobe.
   output wire [`SML_LVL_MSB:0] tx_entry_count, // Transmit entries held.
   output wire [`SML_LVL_MSB:0] rx_entry_count, // Receive entries held.
   output wire rx_full_req, // Raw receive-full request level.
   output wire irq // Interrupt, high while an enabled status bit is set.
);

   reg [`SML_LVL_MSB:0] rx_full_trigger_level_ff;
   reg [`SML_IRQ_W-1:0] irq_status_ff;
   reg [`SML_IRQ_W-1:0] irq_enable_ff;
   reg [`SML_IRQ_W-1:0] nxt_irq_status;
   reg [31:0] hrdata_ff;
   reg [31:0] nxt_hrdata;
   reg wr_pend_ff;
   reg [`SML_ADDR_W-1:0] wr_addr_ff;
   reg rx_full_req_ff;

   wire addr_phase;
   wire wr_data_phase;
   wire [`SML_ADDR_W-1:0] addr_lo;
   wire [`SML_LVL_MSB:0] tx_count;
   wire [`SML_LVL_MSB:0] rx_count;
   wire rx_ovf;
   wire rx_unf;
   wire [`SML_IRQ_W-1:0] irq_events;
   wire [`SML_IRQ_W-1:0] clr_mask;
   wire thresh_wr_ok;

   // Zero-padded register word from a narrow field; upper bits read as zero.
   function [31:0] pad_field;
      input [`SML_LVL_MSB:0] field;
      begin
         pad_field = {28'h0000000, field};
      end
   endfunction

   // Write-strobe decode shared by every writable register.
   function wr_hit;
      input pend;
      input [`SML_ADDR_W-1:0] a;
      input [`SML_ADDR_W-1:0] ofs;
      begin
         wr_hit = pend && (a == ofs);
      end
   endfunction

   sml_level_cnt #(
      .DEPTH(TX_DEPTH)
   )
   u_tx_cnt
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(hce),
      .push(tx_push),
      .pop(tx_pop),
      .count(tx_count),
      .overflow(),
      .underflow()
   );

   sml_level_cnt #(
      .DEPTH(RX_DEPTH)
   )
   u_rx_cnt
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(hce),
      .push(rx_push),
      .pop(rx_pop),
      .count(rx_count),
      .overflow(rx_ovf),
      .underflow(rx_unf)
   );

   assign tx_entry_count = tx_count;
   assign rx_entry_count = rx_count;

   // Zero wait states; a frozen clock enable stretches the transfer instead of losing it.
   assign hreadyout = hce;
   assign hresp = `SML_HRESP_OKAY;
   assign hrdata = hrdata_ff;

   assign addr_phase = hsel && htrans[`SML_HTRANS_NONSEQ_BIT] && hready && hce;
   assign addr_lo = haddr[`SML_ADDR_W-1:0];
   assign wr_data_phase = wr_pend_ff && hce;

   // Only the threshold field is compared, since the reserved bits are not stored.
   assign thresh_wr_ok = hwdata[`SML_LVL_MSB:0] <= RX_DEPTH;

   // Level condition; the comparison widens by one bit so threshold 15 never wraps.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rx_full_req_ff <= 1'b0;
      end
      else if (hce)
      begin
         rx_full_req_ff <= ({1'b0, rx_count} >= ({1'b0, rx_full_trigger_level_ff} + 5'h01));
      end
   end
   assign rx_full_req = rx_full_req_ff;

   assign irq_events[`SML_IRQ_RX_FULL] = rx_full_req_ff;
   assign irq_events[`SML_IRQ_RX_OVF] = rx_ovf;
   assign irq_events[`SML_IRQ_RX_UNF] = rx_unf;

   assign clr_mask = wr_hit(wr_data_phase, wr_addr_ff, `SML_OFS_IRQ_CLEAR) ?
                     hwdata[`SML_IRQ_W-1:0] : {`SML_IRQ_W{1'b0}};

   // An event in the same cycle as its clear keeps the bit set.
   always @*
   begin
      nxt_irq_status = (irq_status_ff & ~clr_mask) | irq_events;
   end

   assign irq = |(irq_status_ff & irq_enable_ff);

   // Address phase latch; writes complete in the following data phase.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= {`SML_ADDR_W{1'b0}};
      end
      else if (hce)
      begin
         wr_pend_ff <= addr_phase && hwrite;
         if (addr_phase)
         begin
            wr_addr_ff <= addr_lo;
         end
      end
   end

   // Read data is fetched at the address phase so it stands registered in the data phase.
   // Reads have no side effects on any register.
   always @*
   begin
      nxt_hrdata = 32'h00000000;
      if (addr_lo == `SML_OFS_RX_THRESH)
      begin
         nxt_hrdata = pad_field(rx_full_trigger_level_ff);
      end
      else if (addr_lo == `SML_OFS_TX_LEVEL)
      begin
         nxt_hrdata = pad_field(tx_count);
      end
      else if (addr_lo == `SML_OFS_RX_LEVEL)
      begin
         nxt_hrdata = pad_field(rx_count);
      end
      else if (addr_lo == `SML_OFS_IRQ_STATUS)
      begin
         nxt_hrdata = {29'h0, irq_status_ff};
      end
      else if (addr_lo == `SML_OFS_IRQ_ENABLE)
      begin
         nxt_hrdata = {29'h0, irq_enable_ff};
      end
      else
      begin
         nxt_hrdata = 32'h00000000;
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata_ff <= 32'h00000000;
      end
      else if (addr_phase && !hwrite)
      begin
         hrdata_ff <= nxt_hrdata;
      end
   end

   // Software-written registers and the sticky status.
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rx_full_trigger_level_ff <= `SML_THRESH_RST;
         irq_enable_ff <= `SML_IRQ_EN_RST;
         irq_status_ff <= {`SML_IRQ_W{1'b0}};
      end
      else if (hce)
      begin
         irq_status_ff <= nxt_irq_status;
         if (wr_hit(wr_data_phase, wr_addr_ff, `SML_OFS_RX_THRESH) && thresh_wr_ok)
         begin
            rx_full_trigger_level_ff <= hwdata[`SML_LVL_MSB:0];
         end
         if (wr_hit(wr_data_phase, wr_addr_ff, `SML_OFS_IRQ_ENABLE))
         begin
            irq_enable_ff <= hwdata[`SML_IRQ_W-1:0];
         end
      end
   end

endmodule

// >>> pkg/sml_regs.vh
/*
  Register map, field positions and reset values of the serial master FIFO level block.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef SML_REGS_VH
`define SML_REGS_VH

// Byte addresses of the word registers on the AHB-Lite port.
`define SML_ADDR_W 8
`define SML_OFS_RX_THRESH 8'h1C
`define SML_OFS_TX_LEVEL 8'h20
`define SML_OFS_RX_LEVEL 8'h24
`define SML_OFS_IRQ_STATUS 8'h30
`define SML_OFS_IRQ_CLEAR 8'h34
`define SML_OFS_IRQ_ENABLE 8'h38

// Field layout and reset values.
`define SML_LVL_W 4
`define SML_LVL_MSB 3
`define SML_THRESH_RST 4'h0
`define SML_LEVEL_RST 4'h0
`define SML_FIFO_DEPTH 4'h2

// Interrupt status, clear and enable share this layout.
`define SML_IRQ_W 3
`define SML_IRQ_RX_FULL 0
`define SML_IRQ_RX_OVF 1
`define SML_IRQ_RX_UNF 2
`define SML_IRQ_EN_RST 3'h0

// AHB-Lite encodings used by the slave.
`define SML_HTRANS_NONSEQ_BIT 1
`define SML_HRESP_OKAY 1'b0

`endif

// >>> logic/sml_level_cnt.v
/*
  Entry counter for one FIFO: tracks how many entries are held.
  Assumes push and pop strobes come from logic on hclk; no synchronisers.
*/
`timescale 1ns/1ps
`include "sml_regs.vh"

module sml_level_cnt #(
   parameter [`SML_LVL_MSB:0] DEPTH = `SML_FIFO_DEPTH
)
(
   input wire hclk, // Bus clock.
   input wire hresetn, // Asynchronous reset, active low.
   input wire ce, // Clock enable; state frozen while low.
   input wire push, // One entry written into the FIFO.
   input wire pop, // One entry read out of the FIFO.
   output wire [`SML_LVL_MSB:0] count, // Entries currently held.
   output wire overflow, // Push refused because the FIFO is full.
   output wire underflow // Pop refused because the FIFO is empty.
);

   reg [`SML_LVL_MSB:0] count_ff;
   reg [`SML_LVL_MSB:0] nxt_count;
   wire push_ok;
   wire pop_ok;

   // A simultaneous push and pop into a full FIFO is legal: the pop frees the slot.
   assign pop_ok = pop && (count_ff != {`SML_LVL_W{1'b0}});
   assign push_ok = push && ((count_ff < DEPTH) || pop_ok);
   assign overflow = push && !push_ok;
   assign underflow = pop && !pop_ok;
   assign count = count_ff;

   always @*
   begin
      nxt_count = count_ff;
      if (push_ok && !pop_ok)
      begin
         nxt_count = count_ff + 4'h1;
      end
      else if (pop_ok && !push_ok)
      begin
         nxt_count = count_ff - 4'h1;
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         count_ff <= `SML_LEVEL_RST;
      end
      else if (ce)
      begin
         count_ff <= nxt_count;
      end
   end

endmodule

// >>> verification/sml_fifo_level_assertions.sv
/*
  Port checker for the FIFO level block: entry counts, receive-full request, bus response.
  Assumes it is bound to sml_fifo_level with the default depth of 2 entries.
*/
`timescale 1ns/1ps
`include "sml_regs.vh"
module sml_fifo_level_chk
(
   input wire hclk, // Clock.
   input wire hresetn, // Reset, active low.
   input wire hce, // Clock enable.
   input wire hreadyout, // Slave ready.
   input wire hresp, // Response.
   input wire tx_push, // Tx push.
   input wire tx_pop, // Tx pop.
   input wire rx_push, // Rx push.
   input wire rx_pop, // Rx pop.
   input wire [`SML_LVL_MSB:0] tx_entry_count, // Tx count.
   input wire [`SML_LVL_MSB:0] rx_entry_count, // Rx count.
   input wire rx_full_req // Rx full request.
);
   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // An empty receive FIFO can never meet a threshold plus one.
   a_rx_full_empty: assert property (hce && rx_entry_count == 4'h0 |=> !rx_full_req)
      else $error("rx full request with empty fifo");
   a_rx_push_step: assert property (hce && rx_push && !rx_pop && rx_entry_count < 4'h2
      |=> rx_entry_count == $past(rx_entry_count) + 4'h1) else $error("rx push miscounted");
   a_rx_pop_step: assert property (hce && rx_pop && !rx_push && rx_entry_count > 4'h0
      |=> rx_entry_count == $past(rx_entry_count) - 4'h1) else $error("rx pop miscounted");
   a_tx_push_step: assert property (hce && tx_push && !tx_pop && tx_entry_count < 4'h2
      |=> tx_entry_count == $past(tx_entry_count) + 4'h1) else $error("tx push miscounted");
   a_tx_pop_step: assert property (hce && tx_pop && !tx_push && tx_entry_count > 4'h0
      |=> tx_entry_count == $past(tx_entry_count) - 4'h1) else $error("tx pop miscounted");
   a_count_bound: assert property (rx_entry_count <= 4'h2 && tx_entry_count <= 4'h2)
      else $error("count above depth");
   a_frozen_count: assert property (!hce |=> $stable(rx_entry_count) && $stable(tx_entry_count))
      else $error("count moved while frozen");
   a_bus_okay: assert property (hresp == 1'b0 && hreadyout == hce) else $error("bad bus response");
endmodule
bind sml_fifo_level sml_fifo_level_chk u_chk (.hclk, .hresetn, .hce, .hreadyout, .hresp, .tx_push, .tx_pop,
   .rx_push, .rx_pop, .tx_entry_count, .rx_entry_count, .rx_full_req);

// >>> verification/sml_fifo_level_tb_top.sv
/*
  Self-checking bench for the FIFO level block over AHB-Lite and the FIFO strobes.
  Assumes one slave on the bus, so hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
module sml_fifo_level_tb_top;
   logic hclk = 0, hresetn = 0, hce = 1, hwrite = 0, hreadyout, hresp, rx_full_req, irq;
   logic tx_push = 0, tx_pop = 0, rx_push = 0, rx_pop = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0;
   logic [3:0] tx_entry_count, rx_entry_count;
   int n_fail = 0, checks = 0;
   sml_fifo_level dut (.hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .tx_push(tx_push), .tx_pop(tx_pop), .rx_push(rx_push), .rx_pop(rx_pop),
      .tx_entry_count(tx_entry_count), .rx_entry_count(rx_entry_count), .rx_full_req(rx_full_req), .irq(irq));
   initial
   begin
      forever #2.5 hclk = ~hclk;
   end
   task chk(input [31:0] seen, input [31:0] exp, input string nm);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Waits as long as the slave stalls; only the watchdog ends a stuck handshake.
   task bw;
      do
      begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
   endtask
   task acc(input [7:0] a, input w, input [31:0] d);
      @(posedge hclk);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      bw();
      htrans <= 2'h0;
      hwdata <= d;
      bw();
      rd = hrdata;
   endtask
   task rc(input [7:0] a, input [31:0] e, input string nm);
      acc(a, 1'b0, 32'h0);
      chk(rd, e, nm);
   endtask
   task pl(input [3:0] v);
      @(posedge hclk);
      {tx_push, tx_pop, rx_push, rx_pop} <= v;
      @(posedge hclk);
      {tx_push, tx_pop, rx_push, rx_pop} <= 4'h0;
      repeat (3) @(posedge hclk);
   endtask
   task t_reset;
      rc(8'h1C, 32'h0, "thresh");
      rc(8'h20, 32'h0, "tx level");
      rc(8'h24, 32'h0, "rx level");
      rc(8'h30, 32'h0, "status");
      rc(8'h38, 32'h0, "enable");
      rc(8'h04, 32'h0, "unmapped");
      $display("reset test done");
   endtask
   task t_thresh;
      acc(8'h1C, 1'b1, 32'h2);
      rc(8'h1C, 32'h2, "thresh 2");
      acc(8'h1C, 1'b1, 32'h3);
      rc(8'h1C, 32'h2, "thresh 3");
      acc(8'h1C, 1'b1, 32'hFFFFFFF1);
      rc(8'h1C, 32'h1, "thresh rsvd");
      acc(8'h24, 1'b1, 32'h5);
      rc(8'h24, 32'h0, "rx level ro");
      $display("threshold test done");
   endtask
   task t_levels;
      pl(4'h8);
      pl(4'h8);
      rc(8'h20, 32'h2, "tx two");
      pl(4'hC);
      rc(8'h20, 32'h2, "tx push pop");
      pl(4'h4);
      rc(8'h20, 32'h1, "tx one");
      @(posedge hclk);
      hce <= 1'b0;
      tx_push <= 1'b1;
      @(posedge hclk);
      tx_push <= 1'b0;
      @(posedge hclk);
      hce <= 1'b1;
      @(posedge hclk);
      chk(tx_entry_count, 32'h1, "tx frozen");
      pl(4'h4);
      $display("level test done");
   endtask
   task t_irq;
      pl(4'h2);
      chk(rx_full_req, 32'h0, "req one");
      pl(4'h2);
      chk(rx_full_req, 32'h1, "req two");
      rc(8'h24, 32'h2, "rx level a");
      rc(8'h24, 32'h2, "rx level b");
      pl(4'h2);
      rc(8'h30, 32'h3, "status ovf");
      chk(irq, 32'h0, "irq masked");
      acc(8'h38, 1'b1, 32'h1);
      // The enable lands at the edge that ends the write, so look one edge later.
      @(posedge hclk);
      chk(irq, 32'h1, "irq on");
      acc(8'h1C, 1'b1, 32'h2);
      repeat (3) @(posedge hclk);
      chk(rx_full_req, 32'h0, "req thresh 2");
      acc(8'h38, 1'b1, 32'h0);
      @(posedge hclk);
      chk(irq, 32'h0, "irq off");
      pl(4'h1);
      pl(4'h1);
      pl(4'h1);
      chk(rx_entry_count, 32'h0, "rx empty");
      acc(8'h34, 1'b1, 32'h7);
      rc(8'h30, 32'h0, "status clr");
      rc(8'h34, 32'h0, "clear reads");
      $display("interrupt test done");
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_thresh();
      t_levels();
      t_irq();
      print_verdict();
   end
   // The full run needs well under a thousand cycles; this catches a stuck handshake.
   initial
   begin
      #20000;
      n_fail++;
      print_verdict();
   end
endmodule
